//--- src/sccl_pkg.sv
// Purpose: Shared types and constants for the secondary cache lateral coherency block.
// Assumes: Direct-mapped main tag array, 32-bit addresses, 32-byte lines.
// Notes: Array geometry is fixed; all parties run on one system clock.
`default_nettype none

package sccl_pkg;

    localparam int SCCL_ADDR_W = 32;
    localparam int SCCL_OFFSET_W = 5;
    localparam int SCCL_INDEX_W = 4;
    localparam int SCCL_LINES = 16;
    localparam int SCCL_TAG_W = SCCL_ADDR_W - SCCL_OFFSET_W - SCCL_INDEX_W;

    typedef enum logic [1:0] {
        LS_INVALID,
        LS_SHARED_UNMOD,
        LS_EXCL_UNMOD,
        LS_EXCL_MOD
    } sccl_line_state_type;

    typedef enum logic [2:0] {
        OP_READ,
        OP_LOCKED_READ,
        OP_WRITE,
        OP_RWITM,
        OP_PROC_INVALIDATE,
        OP_FLUSH
    } sccl_op_type;

    typedef enum logic [1:0] {
        POL_WRITE_BACK,
        POL_WRITE_THROUGH,
        POL_INHIBIT
    } sccl_policy_type;

    typedef enum logic [1:0] {
        SYS_FILL,
        SYS_FILL_MODIFY,
        SYS_INVALIDATE,
        SYS_COPYBACK
    } sccl_sys_kind_type;

    typedef enum logic [2:0] {
        ACT_NONE,
        ACT_UPDATE,
        ACT_INVALIDATE,
        ACT_COPYBACK,
        ACT_FILL,
        ACT_FILL_MODIFY
    } sccl_action_type;

    typedef enum logic [2:0] {
        FSM_IDLE,
        FSM_EVAL,
        FSM_SNOOP_COPY,
        FSM_VICTIM_COPY,
        FSM_SYS_INVALIDATE,
        FSM_COPYBACK,
        FSM_FILL
    } sccl_fsm_type;

    localparam sccl_line_state_type SCCL_LINE_RESET = LS_INVALID;
    localparam logic [SCCL_TAG_W-1:0] SCCL_TAG_RESET = 23'h000000;
    localparam logic [SCCL_OFFSET_W-1:0] SCCL_OFFSET_ZERO = 5'h00;
    localparam logic SCCL_MODEL_RESET = 1'h0;

endpackage : sccl_pkg

`default_nettype wire

//--- src/sccl_fill_share.sv
// Purpose: Samples the two shared inputs over a line fill.
// Assumes: Both shared inputs are active low and synchronous to clock.
// Notes: Sampling window runs from the cycle after the start up to the first transfer acknowledge.
`default_nettype none

module sccl_fill_share
    import sccl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fill control
    input wire logic fill_start,
    input wire logic system_transfer_ack,
    // Shared inputs
    input wire logic shared_in_early_n,
    input wire logic shared_in_late_n,
    // Results
    output logic fill_shared,
    output logic early_all
);

    logic window_reg;
    logic seen_reg;
    logic all_reg;
    logic shared_now;

    assign shared_now = !shared_in_early_n || !shared_in_late_n;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            window_reg <= 1'b0;
            seen_reg <= 1'b0;
            all_reg <= 1'b0;
        end else if (fill_start) begin
            window_reg <= 1'b1;
            seen_reg <= 1'b0;
            all_reg <= 1'b1;
        end else if (window_reg) begin
            seen_reg <= seen_reg || shared_now;
            all_reg <= all_reg && !shared_in_early_n;
            if (system_transfer_ack) begin
                window_reg <= 1'b0;
            end
        end
    end

    // Exclusive only when neither input was seen over the whole window.
    assign fill_shared = seen_reg || (window_reg && shared_now);
    assign early_all = all_reg && (!window_reg || !shared_in_early_n);

endmodule : sccl_fill_share

`default_nettype wire

//--- src/sccl_line_next.sv
// Purpose: Decides the bus action and final line state for one processor operation.
// Assumes: Inputs are stable while the operation is in progress.
// Notes: Purely combinational.
`default_nettype none

module sccl_line_next
    import sccl_pkg::*;
(
    // Operation
    input wire sccl_op_type op,
    input wire sccl_policy_type policy,
    input wire logic hit,
    input wire sccl_line_state_type cur_state,
    // Model and fill result
    input wire logic three_state,
    input wire logic fill_shared,
    // Decision
    output sccl_action_type action,
    output sccl_line_state_type final_state
);

    sccl_line_state_type clean_state;
    sccl_line_state_type fill_state;

    // The three-state model never uses exclusive-unmodified.
    assign clean_state = three_state ? LS_SHARED_UNMOD : LS_EXCL_UNMOD;
    assign fill_state = (fill_shared || three_state || policy == POL_WRITE_THROUGH) ?
        LS_SHARED_UNMOD : LS_EXCL_UNMOD;

    always_comb begin
        action = ACT_NONE;
        final_state = cur_state;
        if (policy == POL_INHIBIT) begin
            if (hit) begin
                final_state = LS_INVALID;
                action = (cur_state == LS_EXCL_MOD) ? ACT_COPYBACK : ACT_UPDATE;
            end
        end else begin
            case (op)
                OP_READ: begin
                    if (!hit) begin
                        action = ACT_FILL;
                        final_state = fill_state;
                    end
                end
                OP_LOCKED_READ: begin
                    if (!hit) begin
                        action = ACT_FILL;
                        final_state = fill_state;
                    end else if (cur_state == LS_SHARED_UNMOD && policy == POL_WRITE_BACK) begin
                        action = ACT_INVALIDATE;
                        final_state = clean_state;
                    end
                end
                OP_WRITE: begin
                    if (policy == POL_WRITE_BACK) begin
                        if (!hit) begin
                            action = ACT_FILL_MODIFY;
                            final_state = LS_EXCL_MOD;
                        end else if (cur_state == LS_SHARED_UNMOD) begin
                            action = ACT_INVALIDATE;
                            final_state = LS_EXCL_MOD;
                        end else if (cur_state == LS_EXCL_UNMOD) begin
                            action = ACT_UPDATE;
                            final_state = LS_EXCL_MOD;
                        end
                    end
                end
                OP_RWITM: begin
                    if (!hit) begin
                        action = ACT_FILL_MODIFY;
                        final_state = LS_EXCL_MOD;
                    end else if (cur_state == LS_SHARED_UNMOD) begin
                        action = ACT_INVALIDATE;
                        final_state = LS_EXCL_MOD;
                    end else if (cur_state == LS_EXCL_UNMOD) begin
                        action = ACT_UPDATE;
                        final_state = LS_EXCL_MOD;
                    end
                end
                OP_PROC_INVALIDATE: begin
                    if (hit && cur_state == LS_SHARED_UNMOD) begin
                        action = ACT_INVALIDATE;
                        final_state = LS_EXCL_MOD;
                    end else if (hit && cur_state == LS_EXCL_UNMOD) begin
                        action = ACT_UPDATE;
                        final_state = LS_EXCL_MOD;
                    end
                end
                OP_FLUSH: begin
                    if (hit && cur_state == LS_EXCL_MOD) begin
                        action = ACT_COPYBACK;
                        final_state = (policy == POL_WRITE_THROUGH) ? LS_SHARED_UNMOD : clean_state;
                    end
                end
                default: begin
                    action = ACT_NONE;
                end
            endcase
        end
    end

endmodule : sccl_line_next

`default_nettype wire

//--- src/sccl_coherency.sv
// Purpose: Line-state keeper for lateral coherency of a secondary cache.
// Assumes: Processor, snoop and system bus logic all run on clock.
// Notes: Snoops are served only between processor operations.
`default_nettype none

module sccl_coherency
    import sccl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Processor request
    input wire logic proc_req_valid,
    output logic proc_req_ready,
    input wire sccl_op_type proc_op,
    input wire logic [SCCL_ADDR_W-1:0] proc_addr,
    input wire logic cache_inhibit_attr,
    input wire logic write_through_attr,
    // Processor answer
    output logic proc_done,
    output logic proc_hit,
    output sccl_line_state_type proc_line_state,
    // Snoop port
    input wire logic snoop_valid,
    input wire logic snoop_modify,
    input wire logic [SCCL_ADDR_W-1:0] snoop_addr,
    output logic snoop_done,
    output logic snoop_hit_status_out,
    output logic snoop_retry,
    // System bus master requests
    output logic sys_req_valid,
    output sccl_sys_kind_type sys_req_kind,
    output logic [SCCL_ADDR_W-1:0] sys_req_addr,
    input wire logic sys_done,
    input wire logic system_transfer_ack,
    input wire logic shared_in_early_n,
    input wire logic shared_in_late_n,
    // Status
    output logic model_three_state
);

    sccl_fsm_type fsm_reg;
    sccl_fsm_type fsm_next;
    sccl_line_state_type line_state_reg [SCCL_LINES];
    logic [SCCL_TAG_W-1:0] line_tag_reg [SCCL_LINES];
    sccl_op_type op_reg;
    sccl_policy_type policy_reg;
    sccl_policy_type policy_in;
    logic [SCCL_ADDR_W-1:0] addr_reg;
    logic [SCCL_INDEX_W-1:0] snoop_index_reg;
    logic snoop_modify_reg;
    logic model_three_reg;

    logic [SCCL_INDEX_W-1:0] proc_index;
    logic [SCCL_TAG_W-1:0] proc_tag;
    logic [SCCL_INDEX_W-1:0] snoop_index;
    logic [SCCL_TAG_W-1:0] snoop_tag;
    sccl_line_state_type cur_state;
    sccl_line_state_type snoop_state;
    sccl_line_state_type final_state;
    sccl_action_type action;
    logic hit;
    logic snoop_hit;
    logic snoop_accept;
    logic proc_accept;
    logic proc_commit;
    logic snoop_commit;
    logic victim_dirty;
    logic fill_shared;
    logic early_all;
    logic sys_issue;
    sccl_sys_kind_type issue_kind;
    logic [SCCL_ADDR_W-1:0] issue_addr;
    sccl_sys_kind_type fill_kind;
    logic [SCCL_ADDR_W-1:0] line_addr;
    logic [SCCL_ADDR_W-1:0] victim_addr;

    // Lookups.
    assign proc_index = addr_reg[SCCL_OFFSET_W +: SCCL_INDEX_W];
    assign proc_tag = addr_reg[SCCL_ADDR_W-1 -: SCCL_TAG_W];
    assign cur_state = line_state_reg[proc_index];
    assign hit = (cur_state != LS_INVALID) && (line_tag_reg[proc_index] == proc_tag);
    assign snoop_index = snoop_addr[SCCL_OFFSET_W +: SCCL_INDEX_W];
    assign snoop_tag = snoop_addr[SCCL_ADDR_W-1 -: SCCL_TAG_W];
    assign snoop_state = line_state_reg[snoop_index];
    assign snoop_hit = (snoop_state != LS_INVALID) && (line_tag_reg[snoop_index] == snoop_tag);
    assign victim_dirty = (cur_state == LS_EXCL_MOD);
    assign line_addr = {proc_tag, proc_index, SCCL_OFFSET_ZERO};
    assign victim_addr = {line_tag_reg[proc_index], proc_index, SCCL_OFFSET_ZERO};
    assign fill_kind = (action == ACT_FILL_MODIFY) ? SYS_FILL_MODIFY : SYS_FILL;

    // The cycle after a snoop answer is skipped so a held request is not served twice.
    assign snoop_accept = (fsm_reg == FSM_IDLE) && snoop_valid && !snoop_done;
    assign proc_req_ready = (fsm_reg == FSM_IDLE) && !snoop_accept;
    assign proc_accept = proc_req_valid && proc_req_ready;

    always_comb begin
        if (cache_inhibit_attr) begin
            policy_in = POL_INHIBIT;
        end else if (write_through_attr) begin
            policy_in = POL_WRITE_THROUGH;
        end else begin
            policy_in = POL_WRITE_BACK;
        end
    end

    sccl_line_next u_line_next (
        .op(op_reg),
        .policy(policy_reg),
        .hit(hit),
        .cur_state(cur_state),
        .three_state(model_three_reg),
        .fill_shared(fill_shared),
        .action(action),
        .final_state(final_state)
    );

    assign sys_issue = (snoop_accept && snoop_hit && snoop_state == LS_EXCL_MOD)
        || (fsm_reg == FSM_EVAL && action inside {ACT_INVALIDATE, ACT_COPYBACK, ACT_FILL, ACT_FILL_MODIFY})
        || (fsm_reg == FSM_VICTIM_COPY && sys_done);

    sccl_fill_share u_fill_share (
        .clock(clock),
        .reset_n(reset_n),
        .fill_start(sys_issue && issue_kind inside {SYS_FILL, SYS_FILL_MODIFY}),
        .system_transfer_ack(system_transfer_ack),
        .shared_in_early_n(shared_in_early_n),
        .shared_in_late_n(shared_in_late_n),
        .fill_shared(fill_shared),
        .early_all(early_all)
    );

    // Kind and address of the next system bus request.
    always_comb begin
        issue_kind = SYS_COPYBACK;
        issue_addr = line_addr;
        if (fsm_reg == FSM_IDLE) begin
            issue_addr = {snoop_tag, snoop_index, SCCL_OFFSET_ZERO};
        end else if (fsm_reg == FSM_VICTIM_COPY) begin
            issue_kind = fill_kind;
        end else begin
            case (action)
                ACT_INVALIDATE: begin
                    issue_kind = SYS_INVALIDATE;
                end
                ACT_FILL, ACT_FILL_MODIFY: begin
                    if (victim_dirty) begin
                        issue_addr = victim_addr;
                    end else begin
                        issue_kind = fill_kind;
                    end
                end
                default: begin
                    issue_kind = SYS_COPYBACK;
                end
            endcase
        end
    end

    assign proc_commit = (fsm_reg == FSM_EVAL && action inside {ACT_NONE, ACT_UPDATE})
        || (sys_done && fsm_reg inside {FSM_SYS_INVALIDATE, FSM_COPYBACK, FSM_FILL});
    assign snoop_commit = (snoop_accept && !(snoop_hit && snoop_state == LS_EXCL_MOD))
        || (fsm_reg == FSM_SNOOP_COPY && sys_done);

    always_comb begin
        fsm_next = fsm_reg;
        case (fsm_reg)
            FSM_IDLE: begin
                if (snoop_accept && snoop_hit && snoop_state == LS_EXCL_MOD) begin
                    fsm_next = FSM_SNOOP_COPY;
                end else if (proc_accept) begin
                    fsm_next = FSM_EVAL;
                end
            end
            FSM_EVAL: begin
                case (action)
                    ACT_INVALIDATE: fsm_next = FSM_SYS_INVALIDATE;
                    ACT_COPYBACK: fsm_next = FSM_COPYBACK;
                    ACT_FILL, ACT_FILL_MODIFY: fsm_next = victim_dirty ? FSM_VICTIM_COPY : FSM_FILL;
                    default: fsm_next = FSM_IDLE;
                endcase
            end
            FSM_VICTIM_COPY: begin
                if (sys_done) begin
                    fsm_next = FSM_FILL;
                end
            end
            FSM_SNOOP_COPY, FSM_SYS_INVALIDATE, FSM_COPYBACK, FSM_FILL: begin
                if (sys_done) begin
                    fsm_next = FSM_IDLE;
                end
            end
            default: begin
                fsm_next = FSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fsm_reg <= FSM_IDLE;
        end else begin
            fsm_reg <= fsm_next;
        end
    end

    // Latched processor request.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            op_reg <= OP_READ;
            policy_reg <= POL_WRITE_BACK;
            addr_reg <= '0;
        end else if (proc_accept) begin
            op_reg <= proc_op;
            policy_reg <= policy_in;
            addr_reg <= proc_addr;
        end
    end

    // Latched snoop for a pending copyback.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            snoop_index_reg <= '0;
            snoop_modify_reg <= 1'b0;
        end else if (snoop_accept) begin
            snoop_index_reg <= snoop_index;
            snoop_modify_reg <= snoop_modify;
        end
    end

    // Main tag array; reset clears every line at once.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < SCCL_LINES; i++) begin
                line_state_reg[i] <= SCCL_LINE_RESET;
                line_tag_reg[i] <= SCCL_TAG_RESET;
            end
        end else begin
            if (snoop_commit && fsm_reg == FSM_IDLE && snoop_hit) begin
                line_state_reg[snoop_index] <= snoop_modify ? LS_INVALID : LS_SHARED_UNMOD;
            end else if (snoop_commit && fsm_reg == FSM_SNOOP_COPY) begin
                line_state_reg[snoop_index_reg] <= snoop_modify_reg ? LS_INVALID : LS_SHARED_UNMOD;
            end
            if (proc_commit) begin
                line_state_reg[proc_index] <= final_state;
                if (fsm_reg == FSM_FILL) begin
                    line_tag_reg[proc_index] <= proc_tag;
                end
            end
        end
    end

    // A plain fill that saw the early input held throughout selects the three-state model.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            model_three_reg <= SCCL_MODEL_RESET;
        end else if (fsm_reg == FSM_FILL && sys_done && sys_req_kind == SYS_FILL) begin
            model_three_reg <= early_all;
        end
    end

    assign model_three_state = model_three_reg;

    // System bus request, held until the transaction completes.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sys_req_valid <= 1'b0;
            sys_req_kind <= SYS_FILL;
            sys_req_addr <= '0;
        end else begin
            if (sys_done) begin
                sys_req_valid <= 1'b0;
            end
            if (sys_issue) begin
                sys_req_valid <= 1'b1;
                sys_req_kind <= issue_kind;
                sys_req_addr <= issue_addr;
            end
        end
    end

    // Processor answer.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            proc_done <= 1'b0;
            proc_hit <= 1'b0;
            proc_line_state <= LS_INVALID;
        end else begin
            proc_done <= proc_commit;
            if (fsm_reg == FSM_EVAL) begin
                proc_hit <= hit;
            end
            if (proc_commit) begin
                proc_line_state <= final_state;
            end
        end
    end

    // Snoop answer; retry is held while a modified line is copied back first.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            snoop_done <= 1'b0;
            snoop_hit_status_out <= 1'b0;
            snoop_retry <= 1'b0;
        end else begin
            snoop_done <= snoop_commit;
            if (snoop_accept) begin
                snoop_hit_status_out <= snoop_hit;
            end
            if (snoop_accept && snoop_hit && snoop_state == LS_EXCL_MOD) begin
                snoop_retry <= 1'b1;
            end else if (snoop_commit) begin
                snoop_retry <= 1'b0;
            end
        end
    end

endmodule : sccl_coherency

`default_nettype wire

//--- test/sccl_coherency_asserts.sv
// Purpose: Port checks for the coherency block.
// Assumes: One clock, reset_n synchronous low.
// Notes: Bound to the top module.
`default_nettype none
module sccl_coherency_asserts
    import sccl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Watched ports
    input wire logic proc_req_valid,
    input wire logic proc_req_ready,
    input wire sccl_op_type proc_op,
    input wire logic cache_inhibit_attr,
    input wire logic write_through_attr,
    input wire logic proc_done,
    input wire logic proc_hit,
    input wire sccl_line_state_type proc_line_state,
    input wire logic snoop_done,
    input wire logic snoop_hit_status_out,
    input wire logic snoop_retry,
    input wire logic sys_req_valid,
    input wire sccl_sys_kind_type sys_req_kind,
    input wire logic sys_done,
    input wire logic model_three_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clock) begin
        if (proc_req_valid && proc_req_ready) begin
            wr_q <= proc_op == OP_WRITE && !cache_inhibit_attr && !write_through_attr;
        end
    end
    rst_clear_a: assert property ($rose(reset_n) |-> !sys_req_valid && !proc_done && !snoop_retry)
        else $error("outputs busy after reset");
    retry_copy_a: assert property (snoop_retry |-> sys_req_valid && sys_req_kind == SYS_COPYBACK)
        else $error("retry without copyback");
    retry_hit_a: assert property (snoop_retry |-> snoop_hit_status_out)
        else $error("retry without snoop hit");
    retry_end_a: assert property ($fell(snoop_retry) |-> snoop_done)
        else $error("retry ended early");
    req_hold_a: assert property (sys_req_valid && !sys_done |=> sys_req_valid && $stable(sys_req_kind))
        else $error("bus request dropped");
    three_no_eu_a: assert property (proc_done && model_three_state |-> proc_line_state != LS_EXCL_UNMOD)
        else $error("exclusive clean in three-state");
    wb_wmiss_a: assert property (proc_done && wr_q && !proc_hit |-> proc_line_state == LS_EXCL_MOD)
        else $error("write miss not modified");
    proc_answer_a: assert property (proc_req_valid && proc_req_ready |-> ##2 proc_done || sys_req_valid)
        else $error("operation got no answer");
    cover property (snoop_retry);
    cover property (proc_done && model_three_state);
    cover property (sys_done && sys_req_kind == SYS_INVALIDATE);
endmodule : sccl_coherency_asserts
bind sccl_coherency sccl_coherency_asserts chk (.*);
`default_nettype wire

//--- test/sccl_sys_model.sv
// Purpose: Memory and other snooping caches on the system bus.
// Assumes: One request at a time.
// Notes: Shared lines rest at pull-up level outside bus requests, except that hold_early holds the early line low throughout.
`default_nettype none
module sccl_sys_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench controls
    input wire logic [3:0] wait_cycles,
    input wire logic share_early,
    input wire logic share_late,
    input wire logic hold_early,
    // System bus
    input wire logic sys_req_valid,
    output logic sys_done,
    output logic system_transfer_ack,
    output logic shared_in_early_n,
    output logic shared_in_late_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] count_reg;
    always_ff @(posedge clock) begin
        if (!reset_n || !sys_req_valid || sys_done) begin
            count_reg <= 4'h0;
            system_transfer_ack <= 1'b0;
            sys_done <= 1'b0;
        end else begin
            count_reg <= count_reg + 4'h1;
            system_transfer_ack <= count_reg == wait_cycles;
            sys_done <= system_transfer_ack;
        end
    end
    assign shared_in_early_n = !(hold_early || (share_early && sys_req_valid));
    // Late sharing comes at the last legal moment.
    assign shared_in_late_n = !(share_late && system_transfer_ack);
endmodule : sccl_sys_model
`default_nettype wire

//--- test/sccl_coherency_tb.sv
// Purpose: Self-checking bench for the coherency block.
// Assumes: Line states show through proc_line_state.
// Notes: Bus count 2'h3 skips the bus check.
`default_nettype none
module sccl_coherency_tb
    import sccl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, proc_req_ready, proc_done, proc_hit, snoop_done, snoop_hit_status_out, snoop_retry;
    logic sys_req_valid, sys_done, system_transfer_ack, shared_in_early_n, shared_in_late_n, model_three_state;
    logic reset_n = 1'b0, proc_req_valid = 1'b0, snoop_valid = 1'b0, snoop_modify = 1'b0;
    logic cache_inhibit_attr = 1'b0, write_through_attr = 1'b0;
    logic share_early = 1'b0, share_late = 1'b0, hold_early = 1'b0;
    logic [3:0] wait_cycles = 4'h0;
    logic [31:0] proc_addr = 32'h0, snoop_addr = 32'h0, sys_req_addr, last_addr = 32'h0;
    sccl_op_type proc_op = OP_READ;
    sccl_line_state_type proc_line_state;
    sccl_sys_kind_type sys_req_kind;
    int err_total = 0, checked = 0, nbus = 0;
    sccl_coherency dut (.*);
    sccl_sys_model partner (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (sys_done === 1'b1) begin
            nbus <= nbus + 1;
            last_addr <= sys_req_addr;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_for(ref logic sig);
        for (int i = 0; i < 200; i++) begin
            @(negedge clock);
            if (sig === 1'b1) return;
        end
        err_total++;
        end_sim();
    endtask : wait_for
    task automatic op(input sccl_op_type o, input logic [31:0] a, input logic [1:0] pol, input logic h,
                      input sccl_line_state_type s, input logic [1:0] b);
        int n;
        n = nbus;
        proc_op <= o;
        proc_addr <= a;
        {cache_inhibit_attr, write_through_attr} <= pol;
        proc_req_valid <= 1'b1;
        wait_for(proc_req_ready);
        @(posedge clock);
        proc_req_valid <= 1'b0;
        wait_for(proc_done);
        check(proc_hit, h);
        check(proc_line_state, s);
        if (b != 2'h3) check(nbus - n, b);
        @(posedge clock);
    endtask : op
    task automatic snp(input logic [31:0] a, input logic m, input logic h);
        snoop_addr <= a;
        snoop_modify <= m;
        snoop_valid <= 1'b1;
        wait_for(snoop_done);
        check(snoop_hit_status_out, h);
        @(posedge clock);
        snoop_valid <= 1'b0;
    endtask : snp
    task automatic rst();
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
    endtask : rst
    task automatic s_four();
        op(OP_READ, 32'h20, 2'h0, 1'b0, LS_EXCL_UNMOD, 2'h1);
        op(OP_WRITE, 32'h20, 2'h0, 1'b1, LS_EXCL_MOD, 2'h0);
        op(OP_FLUSH, 32'h20, 2'h0, 1'b1, LS_EXCL_UNMOD, 2'h1);
        op(OP_PROC_INVALIDATE, 32'h20, 2'h0, 1'b1, LS_EXCL_MOD, 2'h0);
        $display("four-state test over");
    endtask : s_four
    task automatic s_snoop();
        wait_cycles <= 4'h4;
        snp(32'h20, 1'b0, 1'b1);
        check(last_addr, 32'h20);
        op(OP_READ, 32'h20, 2'h0, 1'b1, LS_SHARED_UNMOD, 2'h0);
        op(OP_WRITE, 32'h20, 2'h0, 1'b1, LS_EXCL_MOD, 2'h1);
        snp(32'h20, 1'b1, 1'b1);
        share_early <= 1'b1;
        op(OP_READ, 32'h20, 2'h0, 1'b0, LS_SHARED_UNMOD, 2'h1);
        share_early <= 1'b0;
        snp(32'h40, 1'b0, 1'b0);
        $display("snoop test over");
    endtask : s_snoop
    task automatic s_fill();
        share_late <= 1'b1;
        op(OP_READ, 32'h40, 2'h0, 1'b0, LS_SHARED_UNMOD, 2'h1);
        share_late <= 1'b0;
        share_early <= 1'b1;
        op(OP_WRITE, 32'h60, 2'h0, 1'b0, LS_EXCL_MOD, 2'h1);
        share_early <= 1'b0;
        op(OP_LOCKED_READ, 32'h40, 2'h0, 1'b1, LS_EXCL_UNMOD, 2'h1);
        op(OP_WRITE, 32'h40, 2'h1, 1'b1, LS_EXCL_UNMOD, 2'h3);
        op(OP_READ, 32'hA0, 2'h1, 1'b0, LS_SHARED_UNMOD, 2'h1);
        op(OP_READ, 32'h60, 2'h2, 1'b1, LS_INVALID, 2'h1);
        op(OP_FLUSH, 32'h40, 2'h0, 1'b1, LS_EXCL_UNMOD, 2'h0);
        $display("fill test over");
    endtask : s_fill
    task automatic s_three();
        hold_early <= 1'b1;
        rst();
        op(OP_READ, 32'h20, 2'h0, 1'b0, LS_SHARED_UNMOD, 2'h1);
        check(model_three_state, 1'b1);
        op(OP_WRITE, 32'h20, 2'h0, 1'b1, LS_EXCL_MOD, 2'h1);
        op(OP_RWITM, 32'h40, 2'h0, 1'b0, LS_EXCL_MOD, 2'h1);
        op(OP_READ, 32'h240, 2'h0, 1'b0, LS_SHARED_UNMOD, 2'h2);
        check(last_addr, 32'h240);
        op(OP_FLUSH, 32'h20, 2'h0, 1'b1, LS_SHARED_UNMOD, 2'h1);
        $display("three-state test over");
    endtask : s_three
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #50000;
        err_total++;
        end_sim();
    end
    initial begin
        rst();
        s_four();
        s_snoop();
        s_fill();
        s_three();
        end_sim();
    end
endmodule : sccl_coherency_tb
`default_nettype wire
